// [src/command_serializer.sv]
// Command serializer: words in, doubled serial frames out, reply back
`timescale 1ns/1ps
`include "cmd_ser_map.svh"
module command_serializer
  import cmd_ser_pkg::*;
#(
  parameter int unsigned REPLY_WAIT_CYC =
    `REPLY_WAIT_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Computer word port
  input  wire logic        word_valid,
  input  wire logic [11:0] word_data,
  output logic             word_ready,
  // Reply port toward the computer
  output logic             reply_valid,
  input  wire logic        reply_ready,
  output logic [11:0]      reply_code,
  output logic             reply_ok,
  output logic             reply_timeout,
  output logic             reply_final,
  // Hardline
  output logic             line_tx,
  input  wire logic        line_rx
);

  // Bit period in cycles, rounded down, at least one
  localparam int unsigned BIT_CYC_RAW = `BIT_TIME_NS / `CLK_PERIOD_NS;
  localparam int unsigned BIT_CYC = (BIT_CYC_RAW < 1) ? 1 : BIT_CYC_RAW;
  localparam logic [15:0] BIT_LAST  = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CYC / 2);
  localparam logic [31:0] WAIT_LAST = 32'(REPLY_WAIT_CYC - 1);
  localparam logic [4:0]  FRAME_LAST = 5'(`FRAME_BITS - 1);
  localparam logic [3:0]  REPLY_LAST = 4'(`REPLY_BITS - 1);
  localparam logic        WORD_LAST = 1'(`WORDS_PER_MSG - 1);

  // Doubled frame: word in the leading half, same word in the trailing half
  function automatic frame_t frame_of(input word_t w);
    frame_of = {w, w};
  endfunction : frame_of

  state_e      state_q;
  frame_t      shift_q;
  logic [15:0] baud_q;
  logic [4:0]  bit_q;
  logic        word_idx_q;
  logic        second_copy_q;
  logic [31:0] wait_q;
  logic [11:0] rx_shift_q;
  logic        rep_ok_d;
  logic        rep_to_q;
  logic        baud_done;
  logic        accept;
  logic        buf_push;
  logic        buf_pop;
  logic        buf_in_ready;
  logic [14:0] buf_in;
  // Two-entry reply buffer, head always in slot 0
  logic [14:0] slot0_q;
  logic [14:0] slot1_q;
  logic        v0_q;
  logic        v1_q;

  // Bit timer and handshake terms
  assign baud_done = (baud_q == BIT_LAST);
  assign accept    = word_valid & word_ready;
  assign rep_ok_d  = (rx_shift_q == `REPLY_OK_CODE) & ~rep_to_q;
  assign buf_in_ready = ~v1_q;
  assign buf_push  = (state_q == ST_DELIVER) & buf_in_ready;
  assign buf_pop   = reply_valid & reply_ready;
  assign buf_in    = {second_copy_q, rep_to_q, rep_ok_d, rx_shift_q};

  // Main sequence
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (baud_done && bit_q == FRAME_LAST) begin
            // Only after both words of a message does a reply follow
            if (word_idx_q == WORD_LAST) begin
              state_q <= ST_RX_WAIT;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_RX_WAIT: begin
          if (line_rx != `LINE_IDLE) begin
            state_q <= ST_RX_BITS;
          end else if (wait_q == WAIT_LAST) begin
            state_q <= ST_DELIVER;
          end
        end
        ST_RX_BITS: begin
          if (baud_done && bit_q == 5'(REPLY_LAST) + 5'h01) begin
            state_q <= ST_DELIVER;
          end
        end
        ST_DELIVER: begin
          // Holds here while the computer stalls the reply buffer
          if (buf_in_ready) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Ready to the computer, dropped from acceptance until the first word is done or the reply is buffered
  always_ff @(posedge clk) begin
    if (reset) begin
      word_ready <= 1'b0;
    end else if (accept) begin
      word_ready <= 1'b0;
    end else if (state_q == ST_SEND && baud_done && bit_q == FRAME_LAST
                 && word_idx_q != WORD_LAST) begin
      word_ready <= 1'b1;
    end else if (state_q == ST_DELIVER && buf_in_ready) begin
      word_ready <= 1'b1;
    end else if (state_q == ST_IDLE) begin
      word_ready <= 1'b1;
    end
  end

  // Bit-period timer; restarts on word acceptance and after each bit, half-bit preloaded while awaiting a reply
  always_ff @(posedge clk) begin
    if (reset) begin
      baud_q <= 16'h0000;
    end else if (accept) begin
      baud_q <= 16'h0000;
    end else if (state_q == ST_RX_WAIT) begin
      // Half a bit preloaded so data is sampled mid-bit
      baud_q <= BIT_LAST - HALF_LAST;
    end else if (baud_done) begin
      baud_q <= 16'h0000;
    end else begin
      baud_q <= baud_q + 16'h0001;
    end
  end

  // Bit counter for frames and replies
  always_ff @(posedge clk) begin
    if (reset) begin
      bit_q <= 5'h00;
    end else if (accept || state_q == ST_RX_WAIT) begin
      bit_q <= 5'h00;
    end else if (baud_done &&
                 (state_q == ST_SEND || state_q == ST_RX_BITS)) begin
      bit_q <= bit_q + 5'h01;
    end
  end

  // Transmit shifter, most significant bit first
  always_ff @(posedge clk) begin
    if (reset) begin
      shift_q <= 24'h000000;
    end else if (accept) begin
      shift_q <= frame_of(word_data);
    end else if (state_q == ST_SEND && baud_done) begin
      shift_q <= {shift_q[22:0], 1'b0};
    end
  end

  // Line driver; idle level between frames
  always_ff @(posedge clk) begin
    if (reset) begin
      line_tx <= `LINE_IDLE;
    end else if (state_q == ST_SEND
                 && !(baud_done && bit_q == FRAME_LAST)) begin
      line_tx <= shift_q[23];
    end else begin
      line_tx <= `LINE_IDLE;
    end
  end

  // Word index within a message: first half, then second half
  always_ff @(posedge clk) begin
    if (reset) begin
      word_idx_q <= 1'b0;
    end else if (state_q == ST_SEND && baud_done
                 && bit_q == FRAME_LAST) begin
      word_idx_q <= ~word_idx_q;
    end
  end

  // Which copy of the message the next reply answers
  always_ff @(posedge clk) begin
    if (reset) begin
      second_copy_q <= 1'b0;
    end else if (buf_push) begin
      // A failed reply restarts the pair so a retry is a first copy
      second_copy_q <= rep_ok_d & ~second_copy_q;
    end
  end

  // Reply timeout counter; a silent line counts as malfunction
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_q <= 32'h00000000;
    end else if (state_q == ST_RX_WAIT) begin
      wait_q <= wait_q + 32'h00000001;
    end else begin
      wait_q <= 32'h00000000;
    end
  end

  // Timeout flag for the pending reply
  always_ff @(posedge clk) begin
    if (reset) begin
      rep_to_q <= 1'b0;
    end else if (state_q == ST_RX_WAIT) begin
      rep_to_q <= (line_rx == `LINE_IDLE) && (wait_q == WAIT_LAST);
    end
  end

  // Reply receive shifter, sampled mid-bit after the start bit
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_shift_q <= 12'h000;
    end else if (state_q == ST_RX_WAIT) begin
      rx_shift_q <= 12'h000;
    end else if (state_q == ST_RX_BITS && baud_done
                 && bit_q != 5'h00) begin
      rx_shift_q <= {rx_shift_q[10:0], line_rx};
    end
  end

  // Reply buffer slot 0 (head); a stall by the computer loses nothing
  always_ff @(posedge clk) begin
    if (reset) begin
      v0_q    <= 1'b0;
      slot0_q <= 15'h0000;
    end else if (buf_pop) begin
      v0_q    <= v1_q | buf_push;
      slot0_q <= v1_q ? slot1_q : buf_in;
    end else if (buf_push && !v0_q) begin
      v0_q    <= 1'b1;
      slot0_q <= buf_in;
    end
  end

  // Reply buffer slot 1
  always_ff @(posedge clk) begin
    if (reset) begin
      v1_q    <= 1'b0;
      slot1_q <= 15'h0000;
    end else if (buf_pop) begin
      v1_q    <= v1_q & buf_push;
      slot1_q <= buf_in;
    end else if (buf_push && v0_q) begin
      v1_q    <= 1'b1;
      slot1_q <= buf_in;
    end
  end

  // Reply outputs straight from the head slot
  assign reply_valid   = v0_q;
  assign reply_code    = slot0_q[11:0];
  assign reply_ok      = slot0_q[12];
  assign reply_timeout = slot0_q[13];
  assign reply_final   = slot0_q[14];

endmodule : command_serializer

// [src/cmd_ser_map.svh]
// Constants for the redundant command serializer
`ifndef CMD_SER_MAP_SVH
`define CMD_SER_MAP_SVH

// Word and frame geometry
`define WORD_BITS      12
`define FRAME_BITS     24
`define WORDS_PER_MSG  2
`define REPLY_BITS     12

// Reply code that means redundant reception confirmed
`define REPLY_OK_CODE  12'hA5A

// Timing, in nanoseconds
`define CLK_PERIOD_NS  4
`define BIT_TIME_NS    1000
`define REPLY_WAIT_NS  1000000

// Line level when idle; a reply starts with a low start bit
`define LINE_IDLE      1'b1

`endif

// [src/cmd_ser_pkg.sv]
// Types for the redundant command serializer
package cmd_ser_pkg;
  typedef logic [11:0] word_t;
  typedef logic [23:0] frame_t;
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_SEND    = 5'h02,
    ST_RX_WAIT = 5'h04,
    ST_RX_BITS = 5'h08,
    ST_DELIVER = 5'h10
  } state_e;
endpackage : cmd_ser_pkg

// [verification/cmd_ser_asserts.sv]
// Port checker for the command serializer
`timescale 1ns/1ps
module cmd_ser_asserts #(
  parameter int unsigned REPLY_WAIT_CYC = 2000
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Word port
  input wire logic        word_valid,
  input wire logic [11:0] word_data,
  input wire logic        word_ready,
  // Reply port
  input wire logic        reply_valid,
  input wire logic        reply_ready,
  input wire logic [11:0] reply_code,
  input wire logic        reply_ok,
  input wire logic        reply_timeout,
  input wire logic        reply_final,
  // Hardline
  input wire logic        line_tx,
  input wire logic        line_rx
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Word taken on this edge
  wire take = word_valid && word_ready;
  // Last reply taken was an ok first copy; a final answer must follow one
  logic first_ok_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      first_ok_q <= 1'b0;
    end else if (reply_valid && reply_ready) begin
      first_ok_q <= reply_ok && !reply_final;
    end
  end

  rst_idle_a: assert property (disable iff (1'b0) reset |=>
    !word_ready && !reply_valid && line_tx) else $error("reset state");
  take_drop_a: assert property (take |=> !word_ready [*8])
    else $error("ready not dropped");
  msb_first_a: assert property (take |-> ##2
    line_tx == $past(word_data[11], 2)) else $error("first bit wrong");
  bit_hold_a: assert property (take |-> ##3
    $stable(line_tx) [*8]) else $error("bit not held");
  ok_code_a: assert property (reply_valid |->
    reply_ok == (reply_code == 12'hA5A && !reply_timeout))
    else $error("ok flag wrong");
  to_zero_a: assert property (reply_valid && reply_timeout |->
    reply_code == 12'h000) else $error("timeout code");
  hold_reply_a: assert property (reply_valid && !reply_ready |=>
    reply_valid && $stable(reply_code) && $stable(reply_final))
    else $error("reply not held");
  final_ok_a: assert property (reply_valid && reply_final |->
    first_ok_q) else $error("final without ok first copy");
  idle_ready_a: assert property (word_ready |-> line_tx)
    else $error("ready in frame");
  // Main scenarios reached
  cover property (take);
  cover property (reply_valid && reply_final);
  cover property (reply_valid && reply_timeout);
  cover property (reply_valid && reply_final && reply_timeout);
endmodule : cmd_ser_asserts

bind command_serializer cmd_ser_asserts #(
  .REPLY_WAIT_CYC(REPLY_WAIT_CYC)) u_chk (.clk(clk), .reset(reset),
  .word_valid(word_valid), .word_data(word_data),
  .word_ready(word_ready), .reply_valid(reply_valid),
  .reply_ready(reply_ready), .reply_code(reply_code),
  .reply_ok(reply_ok), .reply_timeout(reply_timeout),
  .reply_final(reply_final), .line_tx(line_tx), .line_rx(line_rx));

// [verification/remote_decoder_model.sv]
// Behavioural remote decoder that sends serial replies
`timescale 1ns/1ps
module remote_decoder_model #(
  parameter int BIT_CYC = 250
) (
  // Clock and reply request
  input wire logic        clk,
  input wire logic        send,
  input wire logic [11:0] code,
  // Reply wire, pulled high when idle
  output logic            line_rx
);
  initial line_rx = 1'b1;
  // Low start bit then code MSB first; bench picks error codes
  always @(posedge clk) begin
    if (send) begin
      line_rx <= 1'b0;
      repeat (BIT_CYC) @(posedge clk);
      for (int i = 11; i >= 0; i--) begin
        line_rx <= code[i];
        repeat (BIT_CYC) @(posedge clk);
      end
      line_rx <= 1'b1;
    end
  end
endmodule : remote_decoder_model

// [verification/tb_top.sv]
// Self-checking bench for the command serializer
`timescale 1ns/1ps
module tb_top;
  import cmd_ser_pkg::*;
  logic  clk = 1'b0;
  logic  reset = 1'b1;
  logic  word_valid = 1'b0;
  logic  reply_ready = 1'b0;
  logic  send = 1'b0;
  word_t word_data = 12'h000;
  word_t rep_code = 12'hA5A;
  word_t reply_code;
  logic  word_ready, reply_valid, reply_ok, reply_timeout;
  logic  reply_final, line_tx, line_rx;
  int    n_fail = 0;
  int    num_checks = 0;

  // Clock, 4 ns period
  initial forever #2 clk = ~clk;

  // One of three converters; the bench routes every message to this one
  command_serializer #(.REPLY_WAIT_CYC(2000)) i_dut (.clk(clk),
    .reset(reset), .word_valid(word_valid), .word_data(word_data),
    .word_ready(word_ready), .reply_valid(reply_valid),
    .reply_ready(reply_ready), .reply_code(reply_code),
    .reply_ok(reply_ok), .reply_timeout(reply_timeout),
    .reply_final(reply_final), .line_tx(line_tx), .line_rx(line_rx));
  remote_decoder_model i_far (.clk(clk), .send(send), .code(rep_code),
    .line_rx(line_rx));

  function automatic bit exp_ok(word_t c, bit to);
    return c == 12'hA5A && !to;
  endfunction : exp_ok

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // Offer a word, then sample its frame mid-bit
  task automatic send_word(input word_t w);
    logic [23:0] f;
    for (int i = 0; i < 20000 && word_ready !== 1'b1; i++) @(negedge clk);
    chk(word_ready, 1'b1);
    word_valid = 1'b1;
    word_data  = w;
    @(negedge clk);
    word_valid = 1'b0;
    word_data  = ~w;
    repeat (125) @(negedge clk);
    for (int i = 23; i >= 0; i--) begin
      f[i] = line_tx;
      if (i == 12) chk(word_ready, 1'b0);
      repeat (250) @(negedge clk);
    end
    chk(f, {w, w});
  endtask : send_word

  // Two words make a message; far side replies when go is set
  task automatic msg(input word_t a, b, c, input bit go);
    send_word(a);
    chk(word_ready, 1'b1);
    send_word(b);
    chk(word_ready, 1'b0);
    rep_code = c;
    send     = go;
    @(negedge clk);
    send = 1'b0;
  endtask : msg

  // Wait for the buffered reply and compare it without taking it
  task automatic peek(input word_t c, input bit to, input bit fin);
    for (int i = 0; i < 6000 && reply_valid !== 1'b1; i++) @(negedge clk);
    chk(reply_code, c);
    chk(reply_ok, exp_ok(c, to));
    chk(reply_timeout, to);
    chk(reply_final, fin);
  endtask : peek

  // Compare the head reply, then pop it
  task automatic pop(input word_t c, input bit to, input bit fin);
    peek(c, to, fin);
    reply_ready = 1'b1;
    @(negedge clk);
    reply_ready = 1'b0;
    @(negedge clk);
  endtask : pop

  // Main sequence
  initial begin
    word_t w0, w1, bad;
    void'($urandom(30));
    w0  = word_t'($urandom);
    w1  = word_t'($urandom);
    bad = word_t'($urandom);
    if (bad == 12'hA5A) bad = 12'h000;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    // First reply read but left standing, so both buffer slots fill
    msg(w0, w1, 12'hA5A, 1'b1);
    peek(12'hA5A, 1'b0, 1'b0);
    msg(w0, w1, 12'hA5A, 1'b1);
    for (int i = 0; i < 6000 && word_ready !== 1'b1; i++) @(negedge clk);
    chk(word_ready, 1'b1);
    pop(12'hA5A, 1'b0, 1'b0);
    pop(12'hA5A, 1'b0, 1'b1);
    $display("test buffered pair done");
    // Failed first copy, then a retry that counts as a first copy again
    msg(12'hFFF, 12'h000, bad, 1'b1);
    pop(bad, 1'b0, 1'b0);
    msg(12'hFFF, 12'h000, 12'hA5A, 1'b1);
    pop(12'hA5A, 1'b0, 1'b0);
    $display("test error reply done");
    // Second copy meets a silent line: final answer reports malfunction
    msg(12'hFFF, 12'h000, 12'h000, 1'b0);
    pop(12'h000, 1'b1, 1'b1);
    $display("test timeout done");
    // Final copy failed: the bench sends nothing more and closes out
    close_out();
  end

  // Watchdog; a forced mismatch marks the hang
  initial begin
    repeat (90000) @(posedge clk);
    chk(24'h000000, 24'h000001);
    close_out();
  end
endmodule : tb_top
